// File: shared/dsu_cfg.svh
// offsets, bit positions, reset values and widths of the debug serial unit
`ifndef DSU_CFG_SVH
`define DSU_CFG_SVH
// register bus widths
`define DSU_ADDR_W        8
`define DSU_DATA_W        32
`define DSU_CHAR_W        8
// register byte offsets
`define DSU_OFS_CTRL      8'h00
`define DSU_OFS_IRQ_SET   8'h08
`define DSU_OFS_IRQ_CLR   8'h0C
`define DSU_OFS_IRQ_STATE 8'h10
`define DSU_OFS_STATUS    8'h14
`define DSU_OFS_RX_HOLD   8'h18
`define DSU_OFS_TX_HOLD   8'h1C
// control register command bits
`define DSU_CTL_RX_RESET  2
`define DSU_CTL_TX_RESET  3
`define DSU_CTL_RX_ON     4
`define DSU_CTL_RX_OFF    5
`define DSU_CTL_TX_ON     6
`define DSU_CTL_TX_OFF    7
`define DSU_CTL_CLR_ERR   8
// shared bit positions of mask and status
`define DSU_BIT_RX_READY  0
`define DSU_BIT_TX_FREE   1
`define DSU_BIT_RX_DONE   3
`define DSU_BIT_TX_DONE   4
`define DSU_BIT_OVERRUN   5
`define DSU_BIT_FRAME     6
`define DSU_BIT_PARITY    7
`define DSU_BIT_TX_IDLE   9
`define DSU_BIT_TX_BUFE   11
`define DSU_BIT_RX_BUFF   12
`define DSU_BIT_DBG_WR    30
`define DSU_BIT_DBG_RD    31
// implemented interrupt sources
`define DSU_SRC_MASK      32'hC0001AFB
// reset values
`define DSU_RST_MASK      32'h00000000
`endif

// File: shared/dsu_hold_if.sv
// link between register logic and the two holding registers
`timescale 1ns/1ps
`include "dsu_cfg.svh"
interface dsu_hold_if;
   logic                   rx_en;    // receiver enabled
   logic                   rd_take;  // software reads receive holding
   logic                   clr_err;  // clear sticky error flags
   logic                   rx_ready; // character waiting
   logic [`DSU_CHAR_W-1:0] rx_data;  // waiting character
   logic                   ovr;      // overrun flag
   logic                   frm;      // framing flag
   logic                   par;      // parity flag
   logic                   tx_en;    // transmitter enabled
   logic                   tx_rst;   // abort transmit holding
   logic                   wr_stb;   // software writes transmit holding
   logic [`DSU_CHAR_W-1:0] wr_data;  // written character
   logic                   tx_free;  // holding register free
   logic                   tx_idle;  // nothing held or shifting
   // register side
   modport regs (output rx_en, rd_take, clr_err, tx_en, tx_rst, wr_stb,
                 wr_data, input rx_ready, rx_data, ovr, frm, par,
                 tx_free, tx_idle);
   // receive holding side
   modport rx_side (input rx_en, rd_take, clr_err,
                    output rx_ready, rx_data, ovr, frm, par);
   // transmit holding side
   modport tx_side (input tx_en, tx_rst, wr_stb, wr_data,
                    output tx_free, tx_idle);
endinterface

// File: shared/dsu_pkg.sv
// state types of the debug serial unit
package dsu_pkg;
`include "dsu_cfg.svh"
   // receive side holding state
   typedef struct packed {
      logic                   ready;  // unread character present
      logic [`DSU_CHAR_W-1:0] data;   // last received character
      logic                   ovr;    // sticky overrun
      logic                   frm;    // sticky framing error
      logic                   par;    // sticky parity error
   } dsu_rx_state_t;
   // transmit side holding state
   typedef struct packed {
      logic                   full;   // character waits for shifter
      logic [`DSU_CHAR_W-1:0] data;   // waiting character
   } dsu_tx_state_t;
   // top level state
   typedef struct packed {
      logic [`DSU_DATA_W-1:0] mask;   // interrupt enables
      logic [`DSU_DATA_W-1:0] rdata;  // registered read answer
      logic                   rx_en;  // receiver running
      logic                   tx_en;  // transmitter running
   } dsu_top_state_t;
endpackage

// File: verification/dsu_term_model.sv
// shifter side model: takes held chars after a delay, then shifts
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_term_model
   import dsu_pkg::*;
#(
   parameter int BUSY = 8                         // shift time in cycles
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic [3:0]             dly,
   input  wire logic                   tx_char_valid,
   input  wire logic [`DSU_CHAR_W-1:0] tx_char_data,
   output logic                        tx_char_take,
   output logic                        tx_shift_busy,
   output logic [`DSU_CHAR_W-1:0]      last_char
);
   int                                 wait_cnt;  // cycles char waited
   int                                 busy_cnt;  // shift cycles left
   ////////////////////////////////////////////////////////////////////////
   // take only while idle and a char is held, one pulse per char
   always_ff @(posedge sys_clk)
   begin
      tx_char_take <= 1'b0;
      if (!resetn)
      begin
         wait_cnt  <= 0;
         busy_cnt  <= 0;
         last_char <= 8'h00;
      end
      else
      begin
         if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
         if (tx_char_valid && busy_cnt == 0 && !tx_char_take)
         begin
            if (wait_cnt == int'(dly))
            begin
               tx_char_take <= 1'b1;
               last_char    <= tx_char_data;
               busy_cnt     <= BUSY;
               wait_cnt     <= 0;
            end
            else
               wait_cnt <= wait_cnt + 1;
         end
      end
   end
   assign tx_shift_busy = (busy_cnt != 0);
endmodule

// File: verification/test_dsu_top.sv
// self-checking bench of the debug serial unit registers
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module test_dsu_top
   import dsu_pkg::*;
;
   // one ordinary case: mask writes, live levels, expected answers
   typedef struct packed {
      logic [31:0] set_v;
      logic [31:0] clr_v;
      logic [5:0]  lv;
      logic [31:0] mask;
      logic [31:0] stat;
      logic        irq;
   } dsu_row_t;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        rx_stb = 1'b0;
   logic [7:0]  rx_data = 8'h00;
   logic        rx_fe = 1'b0;
   logic        rx_pe = 1'b0;
   logic        tx_char_valid;
   logic [7:0]  tx_char_data;
   logic        tx_char_take;
   logic        tx_shift_busy;
   logic [5:0]  lv = 6'h00;                      // dma and debug levels
   logic        rx_enabled;
   logic        tx_enabled;
   logic        irq;
   logic [3:0]  dly = 4'h6;
   logic [7:0]  last_char;
   logic [31:0] d;
   int          num_errors = 0;
   int          checks_done = 0;
   dsu_row_t    rows [8] = '{
      '{32'hFFFFFFFF, 32'h0, 6'h01, 32'hC0001AFB, 32'h00000008, 1'b1},
      '{32'h0, 32'h00000008, 6'h02, 32'hC0001AF3, 32'h00000010, 1'b1},
      '{32'h0, 32'hFFFFFFFF, 6'h04, 32'h0, 32'h00000800, 1'b0},
      '{32'h00001000, 32'h0, 6'h08, 32'h00001000, 32'h00001000, 1'b1},
      '{32'h40000000, 32'h00001000, 6'h10, 32'h40000000, 32'h40000000, 1'b1},
      '{32'h0, 32'h0, 6'h20, 32'h40000000, 32'h80000000, 1'b0},
      '{32'h0, 32'h0, 6'h3F, 32'h40000000, 32'hC0001818, 1'b1},
      '{32'h0, 32'hFFFFFFFF, 6'h00, 32'h0, 32'h0, 1'b0}};
   always #2.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////
   dsu_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_char_strobe(rx_stb),
      .rx_char_data(rx_data), .rx_frame_error(rx_fe),
      .rx_parity_error(rx_pe), .tx_char_valid(tx_char_valid),
      .tx_char_data(tx_char_data), .tx_char_take(tx_char_take),
      .tx_shift_busy(tx_shift_busy), .rx_dma_transfer_done(lv[0]),
      .tx_dma_transfer_done(lv[1]), .tx_dma_buffer_empty(lv[2]),
      .rx_dma_buffer_full(lv[3]), .dbg_chan_write_pending(lv[4]),
      .dbg_chan_read_pending(lv[5]), .rx_enabled(rx_enabled),
      .tx_enabled(tx_enabled), .irq(irq));
   dsu_term_model u_term (.sys_clk(sys_clk), .resetn(resetn), .dly(dly),
      .tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
      .tx_char_take(tx_char_take), .tx_shift_busy(tx_shift_busy),
      .last_char(last_char));
   ////////////////////////////////////////////////////////////////////////
   // bus cycles, receive strobe, bounded wait and compare
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;                          // answer of this cycle
   endtask
   task automatic put(input logic [7:0] c, input logic fe, input logic pe);
      @(posedge sys_clk);
      rx_stb  <= 1'b1;
      rx_data <= c;
      rx_fe   <= fe;
      rx_pe   <= pe;
      @(posedge sys_clk);
      rx_stb  <= 1'b0;
      rx_data <= ~c;                             // stale data not kept
      rx_fe   <= ~fe;
      rx_pe   <= ~pe;
   endtask
   task automatic wt(ref logic f, input logic v);
      for (int n = 0; n < 64 && f !== v; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      chk("wait", {31'h0, v}, {31'h0, f});
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog against a hung run
   initial
   begin
      #20000;
      num_errors++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(`DSU_OFS_IRQ_STATE);
      chk("mask", 32'h0, d);
      for (int i = 0; i < 8; i++)
      begin
         wr(`DSU_OFS_IRQ_SET, rows[i].set_v);
         wr(`DSU_OFS_IRQ_CLR, rows[i].clr_v);
         lv <= rows[i].lv;
         rd(`DSU_OFS_IRQ_STATE);
         chk("mask", rows[i].mask, d);
         rd(`DSU_OFS_STATUS);
         chk("status", rows[i].stat, d);
         chk("irq", {31'h0, rows[i].irq}, {31'h0, irq});
      end
      rd(8'h40);
      chk("unmapped", 32'h0, d);
      wr(`DSU_OFS_CTRL, 32'h50);
      rd(`DSU_OFS_STATUS);
      chk("idle", 32'h202, d);
      put(8'hA5, 1'b0, 1'b0);
      rd(`DSU_OFS_STATUS);
      chk("ready", 32'h203, d);
      rd(`DSU_OFS_RX_HOLD);
      chk("char", 32'hA5, d);
      rd(`DSU_OFS_STATUS);
      chk("read clears", 32'h202, d);
      put(8'h3C, 1'b1, 1'b0);
      put(8'hC3, 1'b0, 1'b1);
      rd(`DSU_OFS_STATUS);
      chk("errors", 32'h2E3, d);
      rd(`DSU_OFS_RX_HOLD);
      chk("last char", 32'hC3, d);
      rd(`DSU_OFS_STATUS);
      chk("sticky", 32'h2E2, d);
      wr(`DSU_OFS_CTRL, 32'h100);
      rd(`DSU_OFS_STATUS);
      chk("err clear", 32'h202, d);
      put(8'h5A, 1'b0, 1'b0);
      wr(`DSU_OFS_CTRL, 32'h20);
      rd(`DSU_OFS_STATUS);
      chk("rx off", 32'h202, d);
      wr(`DSU_OFS_TX_HOLD, 32'h11);
      rd(`DSU_OFS_STATUS);
      chk("tx full", 32'h0, d);
      wt(tx_shift_busy, 1'b1);
      chk("sent", 32'h11, {24'h0, last_char});
      dly <= 4'h0;
      wr(`DSU_OFS_TX_HOLD, 32'h22);
      rd(`DSU_OFS_STATUS);
      chk("waits", 32'h0, d);
      wt(tx_char_valid, 1'b0);
      wt(tx_shift_busy, 1'b0);
      rd(`DSU_OFS_STATUS);
      chk("drained", 32'h202, d);
      chk("next", 32'h22, {24'h0, last_char});
      dly <= 4'hF;
      wr(`DSU_OFS_TX_HOLD, 32'h44);
      wr(`DSU_OFS_CTRL, 32'h48);
      #1 chk("tx reset", 32'h0, {30'h0, tx_char_valid, tx_enabled});
      wr(`DSU_OFS_CTRL, 32'h80);
      wr(`DSU_OFS_TX_HOLD, 32'h33);
      rd(`DSU_OFS_STATUS);
      chk("tx off", 32'h0, d);
      chk("ignored", 32'h0, {31'h0, tx_char_valid});
      chk("enables", 32'h0, {30'h0, rx_enabled, tx_enabled});
      wr(`DSU_OFS_IRQ_SET, 32'hFFFFFFFF);
      resetn <= 1'b0;
      lv     <= 6'h20;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(`DSU_OFS_STATUS);
      chk("reset", 32'h80000000, d);
      chk("reset irq", 32'h0, {31'h0, irq});
      final_report();
   end
endmodule

// File: verilog/dsu_rx_hold.sv
// receive holding register with ready and sticky line error flags
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_rx_hold
   import dsu_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic                   rx_char_strobe,
   input  wire logic [`DSU_CHAR_W-1:0] rx_char_data,
   input  wire logic                   rx_frame_error,
   input  wire logic                   rx_parity_error,
   dsu_hold_if.rx_side                 hold
);
   dsu_rx_state_t st;       // registered state
   dsu_rx_state_t next_st;  // next state
   logic          take_char; // accepted character

   // characters only count while the receiver runs
   assign take_char = rx_char_strobe & hold.rx_en;

   // clears first, so a new event in the same cycle wins
   always_comb
   begin
      next_st = st;
      if (hold.clr_err)
      begin
         next_st.ovr = 1'b0;
         next_st.frm = 1'b0;
         next_st.par = 1'b0;
      end
      if (hold.rd_take || !hold.rx_en)
         next_st.ready = 1'b0;
      if (take_char)
      begin
         next_st.data  = rx_char_data;
         next_st.ready = 1'b1;
         if (st.ready && !hold.rd_take)
            next_st.ovr = 1'b1;
         if (rx_frame_error)
            next_st.frm = 1'b1;
         if (rx_parity_error)
            next_st.par = 1'b1;
      end
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign hold.rx_ready = st.ready;
   assign hold.rx_data  = st.data;
   assign hold.ovr      = st.ovr;
   assign hold.frm      = st.frm;
   assign hold.par      = st.par;
endmodule

// File: verilog/dsu_top.sv
// register interface, status and interrupt of the debug serial unit
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_top
   import dsu_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic [`DSU_ADDR_W-1:0] reg_addr,
   input  wire logic [`DSU_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [`DSU_DATA_W-1:0]      reg_rdata,
   input  wire logic                   rx_char_strobe,
   input  wire logic [`DSU_CHAR_W-1:0] rx_char_data,
   input  wire logic                   rx_frame_error,
   input  wire logic                   rx_parity_error,
   output logic                        tx_char_valid,
   output logic [`DSU_CHAR_W-1:0]      tx_char_data,
   input  wire logic                   tx_char_take,
   input  wire logic                   tx_shift_busy,
   input  wire logic                   rx_dma_transfer_done,
   input  wire logic                   tx_dma_transfer_done,
   input  wire logic                   tx_dma_buffer_empty,
   input  wire logic                   rx_dma_buffer_full,
   input  wire logic                   dbg_chan_write_pending,
   input  wire logic                   dbg_chan_read_pending,
   output logic                        rx_enabled,
   output logic                        tx_enabled,
   output logic                        irq
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   dsu_top_state_t         st;        // registered state
   dsu_top_state_t         next_st;   // next state
   logic [`DSU_DATA_W-1:0] status;    // live status word
   logic                   wr_ctrl;   // control register write
   logic                   wr_set;    // mask set write
   logic                   wr_clr;    // mask clear write
   dsu_hold_if             hold ();   // link to holding registers

   ////////////////////////////////////////////////////////////////////////
   // write decode
   assign wr_ctrl = reg_wr && (reg_addr == `DSU_OFS_CTRL);
   assign wr_set  = reg_wr && (reg_addr == `DSU_OFS_IRQ_SET);
   assign wr_clr  = reg_wr && (reg_addr == `DSU_OFS_IRQ_CLR);

   // commands towards the holding registers
   assign hold.rd_take = reg_rd && (reg_addr == `DSU_OFS_RX_HOLD);
   assign hold.wr_stb  = reg_wr && (reg_addr == `DSU_OFS_TX_HOLD);
   assign hold.wr_data = reg_wdata[`DSU_CHAR_W-1:0];
   assign hold.clr_err = wr_ctrl && reg_wdata[`DSU_CTL_CLR_ERR];
   assign hold.tx_rst  = wr_ctrl && reg_wdata[`DSU_CTL_TX_RESET];
   assign hold.rx_en   = st.rx_en;
   assign hold.tx_en   = st.tx_en;

   ////////////////////////////////////////////////////////////////////////
   // live status word, every source at its own bit
   always_comb
   begin
      status                     = '0;
      status[`DSU_BIT_RX_READY]  = hold.rx_ready;
      status[`DSU_BIT_TX_FREE]   = hold.tx_free;
      status[`DSU_BIT_RX_DONE]   = rx_dma_transfer_done;
      status[`DSU_BIT_TX_DONE]   = tx_dma_transfer_done;
      status[`DSU_BIT_OVERRUN]   = hold.ovr;
      status[`DSU_BIT_FRAME]     = hold.frm;
      status[`DSU_BIT_PARITY]    = hold.par;
      status[`DSU_BIT_TX_IDLE]   = hold.tx_idle;
      status[`DSU_BIT_TX_BUFE]   = tx_dma_buffer_empty;
      status[`DSU_BIT_RX_BUFF]   = rx_dma_buffer_full;
      status[`DSU_BIT_DBG_WR]    = dbg_chan_write_pending;
      status[`DSU_BIT_DBG_RD]    = dbg_chan_read_pending;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: mask, enables and read answer
   always_comb
   begin
      next_st = st;
      // set and clear of mask bits, zeros leave bits alone
      if (wr_set)
         next_st.mask = st.mask | (reg_wdata & `DSU_SRC_MASK);
      if (wr_clr)
         next_st.mask = st.mask & ~reg_wdata;
      // receiver enable, disable wins over enable
      if (wr_ctrl)
      begin
         if (reg_wdata[`DSU_CTL_RX_RESET] || reg_wdata[`DSU_CTL_RX_OFF])
            next_st.rx_en = 1'b0;
         else if (reg_wdata[`DSU_CTL_RX_ON])
            next_st.rx_en = 1'b1;
         // transmitter enable, disable wins over enable
         if (reg_wdata[`DSU_CTL_TX_RESET] || reg_wdata[`DSU_CTL_TX_OFF])
            next_st.tx_en = 1'b0;
         else if (reg_wdata[`DSU_CTL_TX_ON])
            next_st.tx_en = 1'b1;
      end
      // read answer, valid only in the cycle after the strobe
      next_st.rdata = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            `DSU_OFS_IRQ_STATE:
               next_st.rdata = st.mask;
            `DSU_OFS_STATUS:
               next_st.rdata = status;
            `DSU_OFS_RX_HOLD:
               next_st.rdata[`DSU_CHAR_W-1:0] = hold.rx_data;
            default:
               next_st.rdata = '0;  // write-only or unmapped
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         st.mask  <= `DSU_RST_MASK;
         st.rdata <= '0;
         st.rx_en <= 1'b0;
         st.tx_en <= 1'b0;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata  = st.rdata;
   assign rx_enabled = st.rx_en;
   assign tx_enabled = st.tx_en;
   // any enabled source that is set raises the line
   assign irq        = |(status & st.mask);

   ////////////////////////////////////////////////////////////////////////
   // holding registers
   dsu_rx_hold u_rx_hold (
      .sys_clk         (sys_clk),
      .resetn          (resetn),
      .rx_char_strobe  (rx_char_strobe),
      .rx_char_data    (rx_char_data),
      .rx_frame_error  (rx_frame_error),
      .rx_parity_error (rx_parity_error),
      .hold            (hold.rx_side)
   );

   dsu_tx_hold u_tx_hold (
      .sys_clk       (sys_clk),
      .resetn        (resetn),
      .tx_char_take  (tx_char_take),
      .tx_shift_busy (tx_shift_busy),
      .tx_char_valid (tx_char_valid),
      .tx_char_data  (tx_char_data),
      .hold          (hold.tx_side)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks of the register behaviour

   // ones written to the set register at implemented sources show up in the mask
   property p_mask_set;
      @(posedge sys_clk) disable iff (!resetn)
      wr_set |=> ((st.mask & $past(reg_wdata) & `DSU_SRC_MASK) ==
                  ($past(reg_wdata) & `DSU_SRC_MASK)) &&
                 ((st.mask & ~$past(reg_wdata)) ==
                  ($past(st.mask) & ~$past(reg_wdata)));
   endproperty
   a_mask_set: assert property (p_mask_set)
      else $error("mask set write did not set the bits");

   // ones written to the clear register drop mask bits
   property p_mask_clr;
      @(posedge sys_clk) disable iff (!resetn)
      wr_clr |=> ((st.mask & $past(reg_wdata)) == '0) &&
                 ((st.mask & ~$past(reg_wdata)) ==
                  ($past(st.mask) & ~$past(reg_wdata)));
   endproperty
   a_mask_clr: assert property (p_mask_clr)
      else $error("mask clear write did not clear the bits");

   // mask read returns the mask held at the strobe
   property p_mask_read;
      @(posedge sys_clk) disable iff (!resetn)
      reg_rd && (reg_addr == `DSU_OFS_IRQ_STATE) |=>
         reg_rdata == $past(st.mask);
   endproperty
   a_mask_read: assert property (p_mask_read)
      else $error("mask read returned a wrong value");

   // mask is empty right after reset release
   property p_mask_reset;
      @(posedge sys_clk) disable iff (!resetn)
      $rose(resetn) |-> (st.mask == '0) && !irq;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask not cleared by reset");

   // an accepted character raises receive ready next cycle
   property p_rx_ready;
      @(posedge sys_clk) disable iff (!resetn)
      rx_char_strobe && st.rx_en |=> hold.rx_ready &&
         (hold.rx_data == $past(rx_char_data));
   endproperty
   a_rx_ready: assert property (p_rx_ready)
      else $error("receive ready not set by a character");

   // a read with no new character drops receive ready
   property p_rx_read_clears;
      @(posedge sys_clk) disable iff (!resetn)
      hold.rd_take && !rx_char_strobe |=> !hold.rx_ready;
   endproperty
   a_rx_read_clears: assert property (p_rx_read_clears)
      else $error("receive ready survived a read");

   // a second unread character latches overrun until cleared
   property p_overrun;
      @(posedge sys_clk) disable iff (!resetn)
      rx_char_strobe && st.rx_en && hold.rx_ready && !hold.rd_take
         |=> hold.ovr ##1 (hold.ovr || $past(hold.clr_err));
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not latched");

   // the clear command empties all three error flags
   property p_err_clear;
      @(posedge sys_clk) disable iff (!resetn)
      hold.clr_err && !rx_char_strobe |=>
         !hold.ovr && !hold.frm && !hold.par;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flags not cleared");

   // a write to the transmit holding register while the transmitter runs makes it busy
   property p_tx_write;
      @(posedge sys_clk) disable iff (!resetn)
      hold.wr_stb && st.tx_en && !hold.tx_rst |=>
         !hold.tx_free && tx_char_valid &&
         (tx_char_data == $past(reg_wdata[`DSU_CHAR_W-1:0]));
   endproperty
   a_tx_write: assert property (p_tx_write)
      else $error("transmit holding not taken on write");

   // a waiting character stays put until the shifter takes it
   property p_tx_hold;
      @(posedge sys_clk) disable iff (!resetn)
      tx_char_valid && !tx_char_take && !hold.wr_stb && !hold.tx_rst
         |=> tx_char_valid && $stable(tx_char_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("waiting character lost");

   // idle is never reported while shifting or holding
   property p_tx_idle;
      @(posedge sys_clk) disable iff (!resetn)
      (tx_shift_busy || tx_char_valid || !st.tx_en) |-> !hold.tx_idle;
   endproperty
   a_tx_idle: assert property (p_tx_idle)
      else $error("transmit idle while busy");

   // status read shows the receive dma done level
   property p_rx_done_level;
      @(posedge sys_clk) disable iff (!resetn)
      reg_rd && (reg_addr == `DSU_OFS_STATUS) |=>
         reg_rdata[`DSU_BIT_RX_DONE] == $past(rx_dma_transfer_done);
   endproperty
   a_rx_done_level: assert property (p_rx_done_level)
      else $error("status bit 3 wrong");

   // status read shows the debug write pending level
   property p_dbg_wr_level;
      @(posedge sys_clk) disable iff (!resetn)
      reg_rd && (reg_addr == `DSU_OFS_STATUS) |=>
         reg_rdata[`DSU_BIT_DBG_WR] == $past(dbg_chan_write_pending);
   endproperty
   a_dbg_wr_level: assert property (p_dbg_wr_level)
      else $error("status bit 30 wrong");

   // enabled debug read pending drives the interrupt
   property p_irq_dbg_rd;
      @(posedge sys_clk) disable iff (!resetn)
      dbg_chan_read_pending && st.mask[`DSU_BIT_DBG_RD] |-> irq;
   endproperty
   a_irq_dbg_rd: assert property (p_irq_dbg_rd)
      else $error("interrupt missing for debug read");

   // receive holding read returns the held character
   property p_rx_hold_read;
      @(posedge sys_clk) disable iff (!resetn)
      hold.rd_take |=>
         reg_rdata == {{(`DSU_DATA_W-`DSU_CHAR_W){1'b0}},
                       $past(hold.rx_data)};
   endproperty
   a_rx_hold_read: assert property (p_rx_hold_read)
      else $error("receive holding read wrong");

   // dma and debug levels on a status read
   property p_status_levels;
      @(posedge sys_clk) disable iff (!resetn)
      reg_rd && (reg_addr == `DSU_OFS_STATUS) |=>
         reg_rdata[`DSU_BIT_TX_BUFE] == $past(tx_dma_buffer_empty) &&
         reg_rdata[`DSU_BIT_RX_BUFF] == $past(rx_dma_buffer_full) &&
         reg_rdata[`DSU_BIT_DBG_RD] == $past(dbg_chan_read_pending);
   endproperty
   a_status_levels: assert property (p_status_levels)
      else $error("status level wrong");

   // a stopped receiver reports no character
   property p_rx_off;
      @(posedge sys_clk) disable iff (!resetn)
      !st.rx_en |=> !hold.rx_ready;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("receive ready while receiver off");

   // a taken char frees the holding register
   property p_tx_take;
      @(posedge sys_clk) disable iff (!resetn)
      tx_char_take && !hold.wr_stb |=>
         !tx_char_valid && (hold.tx_free == st.tx_en);
   endproperty
   a_tx_take: assert property (p_tx_take)
      else $error("holding register not freed");
endmodule

// File: verilog/dsu_tx_hold.sv
// transmit holding register feeding the external shifter
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_tx_hold
   import dsu_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic                   tx_char_take,
   input  wire logic                   tx_shift_busy,
   output logic                        tx_char_valid,
   output logic [`DSU_CHAR_W-1:0]      tx_char_data,
   dsu_hold_if.tx_side                 hold
);
   dsu_tx_state_t st;       // registered state
   dsu_tx_state_t next_st;  // next state

   // shifter takes the held character, software refills it
   always_comb
   begin
      next_st = st;
      if (tx_char_take)
         next_st.full = 1'b0;
      if (hold.wr_stb && hold.tx_en)
      begin
         next_st.full = 1'b1;
         next_st.data = hold.wr_data;
      end
      if (hold.tx_rst)
         next_st.full = 1'b0;
   end

   // state register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end

   // held character drains even after a transmitter off, only a transmit reset drops it
   assign tx_char_valid = st.full;
   assign tx_char_data  = st.data;
   assign hold.tx_free  = hold.tx_en & ~st.full;
   assign hold.tx_idle  = hold.tx_en & ~st.full & ~tx_shift_busy;
endmodule
